//--- design/nsu_alu.v
// Purpose: 4-bit binary or decimal subtract with borrow in
// Assumes: decimal operands are valid BCD digits
// Notes: combinational
`timescale 1ns/1ps
`include "nsu_defs.vh"
module nsu_alu (
	input wire [3:0] minuend,
	input wire [3:0] subtrahend,
	input wire borrow_in,
	input wire decimal,
	output reg [3:0] diff,
	output reg borrow_out
);
	reg [4:0] raw;
	always @* begin
		raw = {1'b0, minuend} - {1'b0, subtrahend} - {4'h0, borrow_in};
		borrow_out = raw[4];
		diff = raw[3:0];
		// decimal correction only on borrow; raw stays otherwise
		if (decimal && raw[4]) begin // RULE_08
			diff = raw[3:0] - `NSU_BCD_BIAS; // RULE_09
		end
	end
endmodule

//--- design/nsu_decode.v
// Purpose: split the instruction word and classify the subtract forms
// Assumes: the with-borrow form is flagged by the decoder, not by opcode
// Notes: purely combinational
`timescale 1ns/1ps
`include "nsu_defs.vh"
module nsu_decode (
	input wire [15:0] instr,
	input wire borrow_form,
	output wire is_reg_form,
	output wire is_imm_form,
	output wire use_borrow,
	output wire [2:0] row_field,
	output wire [3:0] column_field,
	output wire [3:0] low_field
);
	wire [4:0] opc;
	assign opc = instr[`NSU_OPC_MSB:`NSU_OPC_LSB];
	assign row_field = instr[`NSU_ROW_MSB:`NSU_ROW_LSB];
	assign column_field = instr[`NSU_COL_MSB:`NSU_COL_LSB];
	assign low_field = instr[`NSU_LOW_MSB:`NSU_LOW_LSB];
	// borrow form opcode is supplied by the decoder strobe only
	assign is_reg_form = (opc == `NSU_OPC_SUB_RM) | borrow_form; // RULE_01
	assign is_imm_form = (opc == `NSU_OPC_SUB_MI) & ~borrow_form; // RULE_12
	assign use_borrow = borrow_form; // RULE_15
endmodule

//--- design/nsu_defs.vh
// Purpose: constants of the nibble subtract unit
// Assumes: 16-bit instruction word, 4-bit data
// Notes: definitions only
`ifndef NSU_DEFS_VH
`define NSU_DEFS_VH
`define NSU_OPC_MSB 15
`define NSU_OPC_LSB 11
`define NSU_ROW_MSB 10
`define NSU_ROW_LSB 8
`define NSU_COL_MSB 7
`define NSU_COL_LSB 4
`define NSU_LOW_MSB 3
`define NSU_LOW_LSB 0
`define NSU_OPC_SUB_RM 5'h01
`define NSU_OPC_SUB_MI 5'h11
`define NSU_ADDR_W 11
`define NSU_BCD_BIAS 4'h6
`define NSU_RST_NIB 4'h0
`define NSU_RST_ADDR 11'h000
`endif

//--- design/nsu_top.v
// Purpose: subtract datapath of a 4-bit controller core
// Assumes: one clock, operands presented by decoder and data memory
// Notes: one instruction per ISSUE pulse, result one cycle later
// What this block does
// RULE_01: the register-minus-memory form decodes from a 5-bit opcode then row, column and register fields.
// RULE_02: with compare clear that form writes register minus memory back into the register.
// RULE_03: with compare set no form writes its difference but carry and zero still update.
// RULE_04: carry is set on a borrow and cleared otherwise, whatever compare is.
// RULE_05: a nonzero result always clears zero.
// RULE_06: a zero result with compare clear sets zero.
// RULE_07: a zero result with compare set leaves zero untouched.
// RULE_08: the decimal flag selects binary or decimal subtraction.
// RULE_09: with decimal set and compare clear the corrected difference is written.
// RULE_10: the register operand uses only its column, in the row the register pointer picks.
// RULE_11: with the offset enable set the memory address is the offset pointer ORed with the operand.
// RULE_12: the memory-minus-immediate form decodes its opcode, fields and low immediate nibble.
// RULE_13: with compare clear that form writes memory minus immediate back to memory.
// RULE_14: with compare set that form leaves memory unchanged and updates only flags.
// RULE_15: the with-borrow form subtracts memory and carry from the register.
// RULE_16: the with-borrow form stores only when compare is clear.
// RULE_17: software starts a multi-nibble compare with compare and zero both set.
`timescale 1ns/1ps
`include "nsu_defs.vh"
module nsu_top (
	input wire CLK,
	input wire RSTN,
	input wire CE,
	input wire ISSUE,
	input wire BORROW_FORM,
	input wire [15:0] INSTR,
	input wire [3:0] MEM_RDATA,
	input wire [3:0] REG_RDATA,
	input wire [2:0] REGISTER_POINTER_HIGH,
	input wire [3:0] REGISTER_POINTER_LOW,
	input wire [10:0] OFFSET_POINTER,
	input wire OFFSET_POINTER_ENABLE,
	input wire COMPARE_FLAG,
	input wire DECIMAL_FLAG,
	input wire FLAG_LOAD,
	input wire CARRY_LOAD_VAL,
	input wire ZERO_LOAD_VAL,
	output reg [10:0] MEM_ADDR,
	output reg [10:0] REG_ADDR,
	output reg MEM_WE,
	output reg REG_WE,
	output reg [3:0] WDATA,
	output reg CARRY_FLAG,
	output reg ZERO_FLAG,
	output reg DONE
);
	reg rst_s1_reg;
	reg rst_s2_reg;
	wire rst_n;
	wire is_reg;
	wire is_imm;
	wire use_borrow;
	wire [2:0] row_field;
	wire [3:0] column_field;
	wire [3:0] low_field;
	wire [3:0] diff;
	wire borrow;
	reg [3:0] minuend;
	reg [3:0] subtrahend;
	reg [10:0] mem_addr_next;
	reg [10:0] reg_addr_next;

	// effective address: operand ORed with the offset pointer when enabled
	function [10:0] eff_addr;
		input [10:0] operand;
		input [10:0] offset;
		input en;
		begin
			eff_addr = en ? (operand | offset) : operand; // RULE_11
		end
	endfunction

	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end
	assign rst_n = rst_s2_reg;

	nsu_decode u_dec (
		.instr(INSTR),
		.borrow_form(BORROW_FORM),
		.is_reg_form(is_reg),
		.is_imm_form(is_imm),
		.use_borrow(use_borrow),
		.row_field(row_field),
		.column_field(column_field),
		.low_field(low_field)
	);

	always @* begin
		mem_addr_next = eff_addr({4'h0, row_field, column_field},
			OFFSET_POINTER, OFFSET_POINTER_ENABLE);
		// register side: pointer row, instruction's low field as column
		reg_addr_next = {REGISTER_POINTER_HIGH, REGISTER_POINTER_LOW,
			low_field}; // RULE_10
		if (is_imm) begin
			minuend = MEM_RDATA;
			subtrahend = low_field; // RULE_13
		end else begin
			minuend = REG_RDATA; // RULE_02
			subtrahend = MEM_RDATA;
		end
	end

	nsu_alu u_alu (
		.minuend(minuend),
		.subtrahend(subtrahend),
		.borrow_in(use_borrow & CARRY_FLAG), // RULE_15
		.decimal(DECIMAL_FLAG),
		.diff(diff),
		.borrow_out(borrow)
	);

	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			MEM_ADDR <= `NSU_RST_ADDR;
			REG_ADDR <= `NSU_RST_ADDR;
			MEM_WE <= 1'b0;
			REG_WE <= 1'b0;
			WDATA <= `NSU_RST_NIB;
			CARRY_FLAG <= 1'b0;
			ZERO_FLAG <= 1'b0;
			DONE <= 1'b0;
		end else if (CE) begin
			MEM_ADDR <= mem_addr_next;
			REG_ADDR <= reg_addr_next;
			MEM_WE <= 1'b0;
			REG_WE <= 1'b0;
			DONE <= 1'b0;
			if (ISSUE && (is_reg || is_imm)) begin
				WDATA <= diff; // RULE_09
				DONE <= 1'b1;
				// compare mode suppresses the write, flags still move
				REG_WE <= is_reg & ~COMPARE_FLAG; // RULE_03 RULE_16
				MEM_WE <= is_imm & ~COMPARE_FLAG; // RULE_14
				CARRY_FLAG <= borrow; // RULE_04
				if (diff != 4'h0) begin
					ZERO_FLAG <= 1'b0; // RULE_05
				end else if (!COMPARE_FLAG) begin
					ZERO_FLAG <= 1'b1; // RULE_06
				end
				// zero with compare set keeps the chained result
				// RULE_07
			end else if (FLAG_LOAD) begin
				// software presets flags before a compare chain
				CARRY_FLAG <= CARRY_LOAD_VAL; // RULE_17
				ZERO_FLAG <= ZERO_LOAD_VAL;
			end
		end
	end
endmodule

//--- testbench/nsu_mem_model.sv
// Purpose: data memory holding the general registers
// Assumes: registers share the data space
// Notes: reads follow instr at once
`timescale 1ns/1ps
module nsu_mem_model (
	input wire clk,
	input wire [15:0] instr,
	input wire [6:0] rp,
	input wire [10:0] ofs,
	input wire en,
	input wire [10:0] ma,
	input wire [10:0] ra,
	input wire mwe,
	input wire rwe,
	input wire [3:0] wd,
	output wire [3:0] mrd,
	output wire [3:0] rrd
);
	reg [3:0] m [0:2047];
	assign mrd = m[{4'h0, instr[10:4]} | (en ? ofs : 11'h000)];
	assign rrd = m[{rp, instr[3:0]}];
	always @(posedge clk) begin
		if (mwe) m[ma] <= wd;
		if (rwe) m[ra] <= wd;
	end
endmodule

//--- testbench/nsu_top_chk.sv
// Purpose: port checker of nsu_top
// Assumes: CE low freezes every output
// Notes: flags judged only where no model is needed
`timescale 1ns/1ps
module nsu_top_chk (
	input wire CLK,
	input wire RSTN,
	input wire CE,
	input wire ISSUE,
	input wire BORROW_FORM,
	input wire [15:0] INSTR,
	input wire COMPARE_FLAG,
	input wire [10:0] OFFSET_POINTER,
	input wire OFFSET_POINTER_ENABLE,
	input wire [10:0] MEM_ADDR,
	input wire MEM_WE,
	input wire REG_WE,
	input wire [3:0] WDATA,
	input wire ZERO_FLAG,
	input wire DONE
);
	wire rm = INSTR[15:11] == 5'h01;
	wire mi = INSTR[15:11] == 5'h11;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	AST_TAKE: assert property (CE && ISSUE && (rm || mi) |=> DONE)
		else $error("no done");
	AST_DROP: assert property (ISSUE && !rm && !mi && !BORROW_FORM |=> !DONE)
		else $error("bad op done");
	AST_CMP: assert property (ISSUE && COMPARE_FLAG |=> !MEM_WE && !REG_WE)
		else $error("write in compare");
	AST_RW: assert property (CE && ISSUE && rm && !COMPARE_FLAG
		|=> REG_WE && !MEM_WE) else $error("reg write");
	AST_MW: assert property (CE && ISSUE && mi && !BORROW_FORM
		&& !COMPARE_FLAG |=> MEM_WE && !REG_WE) else $error("mem write");
	AST_NZ: assert property (DONE && WDATA != 4'h0 |-> !ZERO_FLAG)
		else $error("zero on nonzero");
	AST_ZK: assert property (ISSUE && COMPARE_FLAG && !ZERO_FLAG |=> !ZERO_FLAG)
		else $error("zero set in compare");
	AST_FRZ: assert property (!CE && !DONE |=> !DONE && $stable(ZERO_FLAG)
		&& $stable(WDATA)) else $error("state moved while frozen");
	AST_EA: assert property (CE && ISSUE |=> MEM_ADDR ==
		({4'h0, $past(INSTR[10:4])} |
		($past(OFFSET_POINTER_ENABLE) ? $past(OFFSET_POINTER) : 11'h000)))
		else $error("address");
endmodule

//--- testbench/tb_nsu_top.sv
// Purpose: directed test of nsu_top
// Assumes: CE high except during the final freeze check
// Notes: results checked one cycle after issue
`timescale 1ns/1ps
module tb_nsu_top;
	reg clk = 0, rstn = 0, issue = 0, bf = 0, cmp = 0, dec = 0, fl = 0, zl = 0, en = 0;
	reg ce = 1;
	reg [15:0] instr = 16'h0000;
	reg [6:0] rp = 7'h00;
	wire [3:0] mrd, rrd, wd;
	wire [10:0] ma, ra;
	wire mwe, rwe, cy, z, done;
	integer mismatches = 0, checks_done = 0;
	nsu_top i_dut (.CLK(clk), .RSTN(rstn), .CE(ce), .ISSUE(issue),
		.BORROW_FORM(bf), .INSTR(instr), .MEM_RDATA(mrd), .REG_RDATA(rrd),
		.REGISTER_POINTER_HIGH(rp[6:4]), .REGISTER_POINTER_LOW(rp[3:0]),
		.OFFSET_POINTER(11'h040), .OFFSET_POINTER_ENABLE(en), .COMPARE_FLAG(cmp),
		.DECIMAL_FLAG(dec), .FLAG_LOAD(fl), .CARRY_LOAD_VAL(1'b0),
		.ZERO_LOAD_VAL(zl), .MEM_ADDR(ma), .REG_ADDR(ra), .MEM_WE(mwe),
		.REG_WE(rwe), .WDATA(wd), .CARRY_FLAG(cy), .ZERO_FLAG(z), .DONE(done));
	nsu_mem_model i_mem (.clk(clk), .instr(instr), .rp(rp), .ofs(11'h040),
		.en(en), .ma(ma), .ra(ra), .mwe(mwe), .rwe(rwe), .wd(wd), .mrd(mrd),
		.rrd(rrd));
	initial forever #4 clk = ~clk;
	task chk(input string n, input [3:0] e, input [3:0] s);
		begin
			checks_done = checks_done + 1;
			if (e !== s) begin
				mismatches = mismatches + 1;
				$display("BAD %0s exp %h got %h", n, e, s);
			end
		end
	endtask
	task op(input [15:0] i, input b, c, d, input [3:0] w, input y, q);
		begin
			instr = i; bf = b; cmp = c; dec = d; issue = 1;
			@(negedge clk) issue = 0;
			chk("wdata", w, wd);
			chk("flags", {1'b1, y, q, 1'b0}, {done, cy, z, 1'b0});
			@(negedge clk) $display("op %h over", i);
		end
	endtask
	task give_verdict;
		begin
			$display("checks %0d mismatches %0d", checks_done, mismatches);
			if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
			else $display("TESTS FAILED");
			$finish;
		end
	endtask
	initial begin
		#20000 mismatches = mismatches + 1;
		give_verdict;
	end
	initial begin
		repeat (6) @(negedge clk);
		rstn = 1;
		repeat (3) @(negedge clk);
		i_mem.m[3] = 4'h7; i_mem.m[47] = 4'h3;
		op(16'h0af3, 0, 0, 0, 4'h4, 0, 0);
		chk("r03", 4'h4, i_mem.m[3]);
		i_mem.m[47] = 4'h5;
		op(16'h0af3, 0, 1, 0, 4'hf, 1, 0);
		chk("r03", 4'h4, i_mem.m[3]);
		fl = 1; zl = 1;
		@(negedge clk) fl = 0;
		i_mem.m[47] = 4'h4;
		op(16'h0af3, 0, 1, 0, 4'h0, 0, 1);
		i_mem.m[47] = 4'h3;
		op(16'h0af3, 1, 1, 0, 4'h1, 0, 0);
		i_mem.m[47] = 4'h5;
		op(16'h0af3, 0, 1, 0, 4'hf, 1, 0);
		i_mem.m[47] = 4'h3;
		op(16'h0af3, 1, 0, 0, 4'h0, 0, 1);
		chk("r03", 4'h0, i_mem.m[3]);
		op(16'h8af5, 0, 0, 0, 4'he, 1, 0);
		chk("m2f", 4'he, i_mem.m[47]);
		en = 1; i_mem.m[111] = 4'h9;
		op(16'h8af5, 0, 0, 0, 4'h4, 0, 0);
		op(16'h8af5, 0, 1, 0, 4'hf, 1, 0);
		chk("m6f", 4'h4, i_mem.m[111]);
		en = 0; i_mem.m[3] = 4'h3; i_mem.m[47] = 4'h5;
		op(16'h0af3, 0, 0, 1, 4'h8, 1, 0);
		chk("r03", 4'h8, i_mem.m[3]);
		rp = 7'h02; i_mem.m[35] = 4'h9; i_mem.m[47] = 4'h5;
		op(16'h0af3, 0, 0, 0, 4'h4, 0, 0);
		chk("r23", 4'h4, i_mem.m[35]);
		instr = 16'hf000; issue = 1;
		@(negedge clk) issue = 0;
		chk("refused", 4'h0, {3'h0, done});
		@(negedge clk) ce = 0;
		instr = 16'h0af3; cmp = 0; bf = 0; issue = 1;
		@(negedge clk) issue = 0;
		chk("frozen", 4'h0, {3'h0, done});
		chk("r23", 4'h4, i_mem.m[35]);
		@(negedge clk) ce = 1;
		$display("freeze over");
		give_verdict;
	end
endmodule
bind nsu_top nsu_top_chk i_chk (.CLK(CLK), .RSTN(RSTN), .CE(CE), .ISSUE(ISSUE),
	.BORROW_FORM(BORROW_FORM), .INSTR(INSTR), .COMPARE_FLAG(COMPARE_FLAG),
	.OFFSET_POINTER(OFFSET_POINTER), .OFFSET_POINTER_ENABLE(OFFSET_POINTER_ENABLE),
	.MEM_ADDR(MEM_ADDR), .MEM_WE(MEM_WE), .REG_WE(REG_WE), .WDATA(WDATA),
	.ZERO_FLAG(ZERO_FLAG), .DONE(DONE));
